// >>> dv/fault_bus_peer.sv
// Peer controllers and external pullup on the shared fault bus
`timescale 1ns/1ns
`default_nettype none

module fault_bus_peer #(
    parameter int PEERS = 14                // Other controllers, fifteen in all at most
) (
    input  wire logic dutOe,                // Block under test sinks the bus
    input  wire logic peerFault,            // One peer reports a fault
    input  wire logic strongPullup,         // External pullup stronger than any sink
    output logic      busLevel,             // Resolved bus level
    output logic      peerOff               // Peers have shut their outputs
);
    // Wired-low bus; only a strong external pullup beats the sinks
    assign busLevel = strongPullup | ~(dutOe | peerFault);
    // Peers drop their outputs while the bus is low
    assign peerOff = ~busLevel;
endmodule // fault_bus_peer
`default_nettype wire

// >>> dv/led_channel_fault_diagnostics_tb.sv
// Self-checking bench for the LED channel fault diagnostics block
`timescale 1ns/1ns
`default_nettype none

module led_channel_fault_diagnostics_tb;
    // ------------------------------------------------------------------
    // Signals and short counts so every retry fits in a few cycles
    // ------------------------------------------------------------------
    localparam logic [15:0] DEG = 16'h0004;
    localparam logic [15:0] PUL = 16'h0002;
    localparam logic [15:0] OFF = 16'h0004;
    typedef struct {int kind; logic [2:0] val;} note_type;
    logic       mclk = 1'b0, reset_n = 1'b0, diagEnable = 1'b0, peerFault = 1'b0;
    logic       tempAboveShutdown = 1'b0, tempBelowRecover = 1'b0, strongPullup = 1'b0;
    logic [2:0] pwmIn = 3'h0, sgBelowRise = 3'h0, sgAboveFall = 3'h0;
    logic [2:0] openBelowRise = 3'h0, openAboveFall = 3'h0;
    logic       faultBusIn, faultBusOut, faultBusOe, faultPullupEn, chargePumpEn;
    logic       faultMode, thermalShutdown, peerOff;
    logic [2:0] channelOn, retryCurrentEn, groundShortFault, openFault;
    note_type   q[$];
    note_type   nt;
    int         n_fail = 0, check_count = 0;
    event       look;
    string      names[7] = '{"channelOn", "groundShortFault", "openFault", "retryCurrentEn",
                             "busOe_pump_mode", "thermal_pullup_busOut", "zero_busIn_peerOff"};

    led_channel_fault_diagnostics #(.SG_DEG(DEG), .SG_PULSE(PUL), .SG_OFF(OFF),
        .OPEN_DEG(DEG), .OPEN_PULSE(PUL), .OPEN_OFF(OFF)) DUT (.mclk(mclk),
        .reset_n(reset_n), .pwmIn(pwmIn), .diagEnable(diagEnable), .sgBelowRise(sgBelowRise),
        .sgAboveFall(sgAboveFall), .openBelowRise(openBelowRise), .openAboveFall(openAboveFall),
        .tempAboveShutdown(tempAboveShutdown), .tempBelowRecover(tempBelowRecover),
        .faultBusIn(faultBusIn), .faultBusOut(faultBusOut), .faultBusOe(faultBusOe),
        .faultPullupEn(faultPullupEn), .channelOn(channelOn), .retryCurrentEn(retryCurrentEn),
        .groundShortFault(groundShortFault), .openFault(openFault), .chargePumpEn(chargePumpEn),
        .faultMode(faultMode), .thermalShutdown(thermalShutdown));
    fault_bus_peer PEER (.dutOe(faultBusOe), .peerFault(peerFault), .strongPullup(strongPullup),
        .busLevel(faultBusIn), .peerOff(peerOff));

    // 250 MHz clock
    always #2 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Helpers: notes go in a queue, the monitor compares them
    // ------------------------------------------------------------------
    function automatic logic [2:0] seen(int k);
        case (k)
            0: return channelOn;
            1: return groundShortFault;
            2: return openFault;
            3: return retryCurrentEn;
            4: return {faultBusOe, chargePumpEn, faultMode};
            6: return {1'b0, faultBusIn, peerOff};
            default: return {thermalShutdown, faultPullupEn, faultBusOut};
        endcase
    endfunction
    task automatic step(int c);
        repeat (c) @(negedge mclk);
    endtask
    task automatic note(int k, logic [2:0] v);
        q.push_back('{k, v});
        ->look;
    endtask
    // Bounded wait; a timeout shows up as a mismatch in the note
    task automatic wait_for(int k, logic [2:0] v, int lim);
        for (int i = 0; i < lim && seen(k) !== v; i++) @(negedge mclk);
        note(k, v);
    endtask
    task automatic cmp3(int k, logic [2:0] e, logic [2:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", names[k], e, g);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Monitor drains every note against the settled outputs
    always @(look) begin
        while (q.size() > 0) begin
            nt = q.pop_front();
            cmp3(nt.kind, nt.val, seen(nt.kind));
        end
    end

    // Watchdog, far beyond the two hundred or so cycles the sequence needs at most
    initial begin
        step(3000);
        n_fail++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence, inputs change at the falling edge
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h5683));
        step(10);
        reset_n = 1'b1;
        step(2);
        note(4, 3'b010);
        note(5, 3'b010);
        repeat (8) begin
            pwmIn = 3'($urandom);
            step(1);
            note(0, pwmIn);
        end
        // Short while off is not a fault
        pwmIn = 3'h0;
        sgBelowRise = 3'h1;
        step(12);
        note(1, 3'h0);
        // Deglitch restarts twice, then the short persists
        pwmIn = 3'h1;
        sgBelowRise = 3'h0;
        step(2);
        repeat (2) begin
            sgBelowRise = 3'h1;
            step(3);
            sgBelowRise = 3'h0;
            sgAboveFall = 3'h1;
            step(1);
            sgAboveFall = 3'h0;
        end
        note(1, 3'h0);
        sgBelowRise = 3'h1;
        wait_for(1, 3'h1, 12);
        wait_for(4, 3'b101, 4);
        note(6, 3'b001);
        pwmIn = 3'h7;
        step(2);
        note(0, 3'h0);
        wait_for(3, 3'h1, 12);
        step(PUL - 1);
        note(3, 3'h1);
        step(1);
        note(3, 3'h0);
        step(OFF - 1);
        note(3, 3'h0);
        step(1);
        note(3, 3'h1);
        sgBelowRise = 3'h0;
        wait_for(1, 3'h0, 20);
        wait_for(0, 3'h7, 6);
        // Open on an off channel, masked while diagnostics are off
        strongPullup = 1'b1;
        pwmIn = 3'h5;
        openBelowRise = 3'h2;
        step(12);
        note(2, 3'h0);
        diagEnable = 1'b1;
        step(3);
        openBelowRise = 3'h0;
        openAboveFall = 3'h2;
        step(1);
        openAboveFall = 3'h0;
        openBelowRise = 3'h2;
        step(3);
        note(2, 3'h0);
        wait_for(2, 3'h2, 12);
        step(2);
        note(0, 3'h5);
        note(4, 3'b110);
        note(6, 3'b010);
        wait_for(3, 3'h2, 12);
        step(PUL - 1);
        note(3, 3'h2);
        step(1);
        note(3, 3'h0);
        openBelowRise = 3'h0;
        wait_for(2, 3'h0, 20);
        strongPullup = 1'b0;
        // A peer pulls the bus low
        peerFault = 1'b1;
        step(2);
        note(4, 3'b001);
        note(0, 3'h0);
        peerFault = 1'b0;
        wait_for(0, 3'h5, 6);
        // Overtemperature with hysteresis release
        tempAboveShutdown = 1'b1;
        step(1);
        tempAboveShutdown = 1'b0;
        step(3);
        note(5, 3'b100);
        note(4, 3'b101);
        note(0, 3'h0);
        step(5);
        note(5, 3'b100);
        tempBelowRecover = 1'b1;
        step(1);
        tempBelowRecover = 1'b0;
        wait_for(5, 3'b010, 6);
        wait_for(0, 3'h5, 6);
        step(2);
        print_verdict();
    end
endmodule // led_channel_fault_diagnostics_tb
`default_nettype wire

// >>> rtl/led_channel_fault_diagnostics.sv
// Module: per-channel fault detection, auto-retry, thermal shutdown and fault bus
`timescale 1ns/1ns
`default_nettype none

module led_channel_fault_diagnostics #(
    parameter int                   NCH        = led_diag_pkg::CHANNEL_COUNT,
    parameter int                   CW         = led_diag_pkg::COUNT_WIDTH,
    parameter logic [CW-1:0]        SG_DEG     = led_diag_pkg::SG_DEGLITCH_CYCLES,
    parameter logic [CW-1:0]        SG_PULSE   = led_diag_pkg::SG_RETRY_PULSE_CYCLES,
    parameter logic [CW-1:0]        SG_OFF     = led_diag_pkg::SG_RETRY_OFF_CYCLES,
    parameter logic [CW-1:0]        OPEN_DEG   = led_diag_pkg::OPEN_DEGLITCH_CYCLES,
    parameter logic [CW-1:0]        OPEN_PULSE = led_diag_pkg::OPEN_RETRY_PULSE_CYCLES,
    parameter logic [CW-1:0]        OPEN_OFF   = led_diag_pkg::OPEN_RETRY_OFF_CYCLES
) (
    input  wire logic               mclk,             // 250 MHz clock
    input  wire logic               reset_n,          // Synchronous reset, active low
    input  wire logic [NCH-1:0]     pwmIn,            // PWM dimming request per channel
    input  wire logic               diagEnable,       // Diagnostic enable, high allows open check
    input  wire logic [NCH-1:0]     sgBelowRise,      // Sense below ground-short rise threshold
    input  wire logic [NCH-1:0]     sgAboveFall,      // Sense above ground-short fall threshold
    input  wire logic [NCH-1:0]     openBelowRise,    // Supply-sense diff below open rise level
    input  wire logic [NCH-1:0]     openAboveFall,    // Supply-sense diff above open fall level
    input  wire logic               tempAboveShutdown,// Junction at shutdown threshold
    input  wire logic               tempBelowRecover, // Junction below threshold minus hysteresis
    input  wire logic               faultBusIn,       // Fault bus level, low means fault
    output logic                    faultBusOut,      // Fault bus drive value, always low
    output logic                    faultBusOe,       // Fault bus sink enable, high sinks
    output logic                    faultPullupEn,    // Weak internal pullup enable
    output logic [NCH-1:0]          channelOn,        // Gate drive enable per channel
    output logic [NCH-1:0]          retryCurrentEn,   // Retry current source per channel
    output logic [NCH-1:0]          groundShortFault, // Channel in ground-short handling
    output logic [NCH-1:0]          openFault,        // Channel in open / battery-short handling
    output logic                    chargePumpEn,     // Charge pump run enable
    output logic                    faultMode,        // Reduced-current fault mode
    output logic                    thermalShutdown   // Overtemperature protection active
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Deglitch step: clear on release or disable, count while low, saturate at limit.
    // Inside the hysteresis band the count holds, so chatter does not restart it.
    function automatic logic [CW-1:0] nextDeglitch(input logic [CW-1:0] count,
                                                   input logic          enable,
                                                   input logic          below,
                                                   input logic          released,
                                                   input logic [CW-1:0] limit);
        logic [CW-1:0] result;
        result = count;
        if (!enable || released) begin
            result = '0;
        end else if (below && count != limit) begin
            result = count + 1'b1;
        end
        return result;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    led_diag_pkg::chan_state_type chanState [NCH];
    logic [CW-1:0]                sgCount   [NCH];
    logic [CW-1:0]                openCount [NCH];
    logic [CW-1:0]                retryCount[NCH];

    logic busLow;
    logic anyFault;
    logic allOff;

    // Bus low is shared state for every controller; thermal also sinks the bus, so it stops them all unless a strong external pullup holds the bus high
    assign busLow   = !faultBusIn;
    assign allOff   = busLow || thermalShutdown;
    always_comb begin
        anyFault = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            anyFault = anyFault || (chanState[i] != led_diag_pkg::ST_NORMAL);
        end
    end

    // ------------------------------------------------------------------
    // Overtemperature with hysteresis
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            thermalShutdown <= 1'b0;
        end else if (tempAboveShutdown) begin
            thermalShutdown <= 1'b1;
        end else if (tempBelowRecover) begin
            thermalShutdown <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Deglitch counters
    // ------------------------------------------------------------------
    // Ground-short only counts in on-time; open counts on or off so that a
    // battery short on an idle channel is caught too
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                sgCount[i]   <= '0;
                openCount[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                sgCount[i] <= nextDeglitch(sgCount[i],
                    chanState[i] == led_diag_pkg::ST_NORMAL && channelOn[i],
                    sgBelowRise[i], sgAboveFall[i], SG_DEG);
                openCount[i] <= nextDeglitch(openCount[i],
                    chanState[i] == led_diag_pkg::ST_NORMAL && diagEnable,
                    openBelowRise[i], openAboveFall[i], OPEN_DEG);
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel retry state machine
    // ------------------------------------------------------------------
    // Retries keep running in fault mode so the faulty channel can recover
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                chanState[i]  <= led_diag_pkg::ST_NORMAL;
                retryCount[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                retryCount[i] <= retryCount[i] + 1'b1;
                case (chanState[i])
                    led_diag_pkg::ST_NORMAL: begin
                        retryCount[i] <= '0;
                        if (sgCount[i] == SG_DEG) begin
                            chanState[i] <= led_diag_pkg::ST_SG_ON;
                        end else if (openCount[i] == OPEN_DEG) begin
                            chanState[i] <= led_diag_pkg::ST_OPEN_ON;
                        end
                    end
                    led_diag_pkg::ST_SG_ON: begin
                        if (retryCount[i] == SG_PULSE - 1'b1) begin
                            retryCount[i] <= '0;
                            chanState[i]  <= sgBelowRise[i] ? led_diag_pkg::ST_SG_OFF
                                                            : led_diag_pkg::ST_NORMAL;
                        end
                    end
                    led_diag_pkg::ST_SG_OFF: begin
                        if (retryCount[i] == SG_OFF - 1'b1) begin
                            retryCount[i] <= '0;
                            chanState[i]  <= led_diag_pkg::ST_SG_ON;
                        end
                    end
                    led_diag_pkg::ST_OPEN_ON: begin
                        if (retryCount[i] == OPEN_PULSE - 1'b1) begin
                            retryCount[i] <= '0;
                            chanState[i]  <= led_diag_pkg::ST_OPEN_OFF;
                        end
                    end
                    led_diag_pkg::ST_OPEN_OFF: begin
                        if (retryCount[i] == OPEN_OFF - 1'b1) begin
                            retryCount[i] <= '0;
                            chanState[i]  <= openBelowRise[i] ? led_diag_pkg::ST_OPEN_ON
                                                              : led_diag_pkg::ST_NORMAL;
                        end
                    end
                    default: begin
                        chanState[i] <= led_diag_pkg::ST_NORMAL;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel outputs
    // ------------------------------------------------------------------
    // PWM only reaches a channel in normal state; with the bus held high from
    // outside, busLow never rises and only the faulty channel goes dark
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            channelOn        <= '0;
            retryCurrentEn   <= '0;
            groundShortFault <= '0;
            openFault        <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                channelOn[i] <= pwmIn[i] && !allOff
                                && chanState[i] == led_diag_pkg::ST_NORMAL;
                retryCurrentEn[i] <= chanState[i] == led_diag_pkg::ST_SG_ON
                                     || chanState[i] == led_diag_pkg::ST_OPEN_ON;
                groundShortFault[i] <= chanState[i] == led_diag_pkg::ST_SG_ON
                                       || chanState[i] == led_diag_pkg::ST_SG_OFF;
                openFault[i] <= chanState[i] == led_diag_pkg::ST_OPEN_ON
                                || chanState[i] == led_diag_pkg::ST_OPEN_OFF;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fault bus and device mode
    // ------------------------------------------------------------------
    // Sink and pullup are exclusive so the weak source never fights the sink.
    // Up to MAX_BUS_DEVICES sinks may share the wire
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            faultBusOut   <= 1'b0;
            faultBusOe    <= 1'b0;
            faultPullupEn <= 1'b1;
            chargePumpEn  <= 1'b0;
            faultMode     <= 1'b0;
        end else begin
            faultBusOut   <= 1'b0;
            faultBusOe    <= anyFault || thermalShutdown;
            faultPullupEn <= !(anyFault || thermalShutdown);
            chargePumpEn  <= !allOff;
            faultMode     <= allOff;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++) begin : gen_check
        sequence s_sg_pulse_end;
            chanState[g] == led_diag_pkg::ST_SG_ON && retryCount[g] == SG_PULSE - 1'b1;
        endsequence
        sequence s_sg_wait_end;
            chanState[g] == led_diag_pkg::ST_SG_OFF && retryCount[g] == SG_OFF - 1'b1;
        endsequence

        property p_sg_off_time_hold;
            @(posedge mclk) disable iff (!reset_n)
            (chanState[g] == led_diag_pkg::ST_NORMAL && !channelOn[g])
            |=> sgCount[g] == '0;
        endproperty
        a_sg_off_time_hold: assert property (p_sg_off_time_hold)
            else $error("ground-short count moved outside on-time");

        property p_sg_flag;
            @(posedge mclk) disable iff (!reset_n)
            (chanState[g] == led_diag_pkg::ST_NORMAL && sgCount[g] == SG_DEG)
            |=> chanState[g] == led_diag_pkg::ST_SG_ON ##1 retryCurrentEn[g];
        endproperty
        a_sg_flag: assert property (p_sg_flag)
            else $error("ground-short not flagged after deglitch");

        property p_sg_release;
            @(posedge mclk) disable iff (!reset_n)
            sgAboveFall[g] |=> sgCount[g] == '0;
        endproperty
        a_sg_release: assert property (p_sg_release)
            else $error("ground-short deglitch not reset");

        property p_sg_retry_cycle;
            @(posedge mclk) disable iff (!reset_n)
            s_sg_pulse_end ##0 sgBelowRise[g] |=> chanState[g] == led_diag_pkg::ST_SG_OFF
            ##1 !retryCurrentEn[g];
        endproperty
        a_sg_retry_cycle: assert property (p_sg_retry_cycle)
            else $error("ground-short retry pulse did not end in off wait");

        property p_sg_rearm;
            @(posedge mclk) disable iff (!reset_n)
            s_sg_wait_end |=> chanState[g] == led_diag_pkg::ST_SG_ON;
        endproperty
        a_sg_rearm: assert property (p_sg_rearm)
            else $error("no retry pulse after off wait");

        property p_sg_recover;
            @(posedge mclk) disable iff (!reset_n)
            s_sg_pulse_end ##0 !sgBelowRise[g] |=> chanState[g] == led_diag_pkg::ST_NORMAL;
        endproperty
        a_sg_recover: assert property (p_sg_recover)
            else $error("channel did not recover after short removed");

        property p_retry_blocks_pwm;
            @(posedge mclk) disable iff (!reset_n)
            chanState[g] != led_diag_pkg::ST_NORMAL |=> !channelOn[g];
        endproperty
        a_retry_blocks_pwm: assert property (p_retry_blocks_pwm)
            else $error("channel driven during auto-retry");

        property p_open_release;
            @(posedge mclk) disable iff (!reset_n)
            (openAboveFall[g] || !diagEnable) |=> openCount[g] == '0;
        endproperty
        a_open_release: assert property (p_open_release)
            else $error("open deglitch not reset");
    end

    property p_bus_sink;
        @(posedge mclk) disable iff (!reset_n)
        (anyFault || thermalShutdown) |=> faultBusOe && !faultBusOut && !faultPullupEn;
    endproperty
    a_bus_sink: assert property (p_bus_sink)
        else $error("fault bus not sunk on fault");

    property p_thermal_off;
        @(posedge mclk) disable iff (!reset_n)
        thermalShutdown |=> !chargePumpEn && channelOn == '0 && faultBusOe;
    endproperty
    a_thermal_off: assert property (p_thermal_off)
        else $error("outputs active during thermal shutdown");

    property p_bus_low_mode;
        @(posedge mclk) disable iff (!reset_n)
        !faultBusIn |=> faultMode && !chargePumpEn && channelOn == '0;
    endproperty
    a_bus_low_mode: assert property (p_bus_low_mode)
        else $error("fault mode not entered with bus low");

endmodule // led_channel_fault_diagnostics

`default_nettype wire

// >>> rtl/led_diag_pkg.sv
// Package: shared constants and types for the LED channel fault diagnostics block
package led_diag_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int CHANNEL_COUNT   = 3;   // Channels per controller
    localparam int COUNT_WIDTH     = 16;  // Width of deglitch and retry counters
    localparam int MAX_BUS_DEVICES = 15;  // Controllers allowed on one fault bus

    // ------------------------------------------------------------------
    // Timing counts in mclk cycles (no time values exist, plain defaults)
    // ------------------------------------------------------------------
    localparam logic [15:0] SG_DEGLITCH_CYCLES     = 16'h0040; // Ground-short deglitch
    localparam logic [15:0] SG_RETRY_PULSE_CYCLES  = 16'h0020; // Ground-short retry pulse
    localparam logic [15:0] SG_RETRY_OFF_CYCLES    = 16'h0100; // Ground-short retry off
    localparam logic [15:0] OPEN_DEGLITCH_CYCLES   = 16'h0040; // Open-load deglitch
    localparam logic [15:0] OPEN_RETRY_PULSE_CYCLES = 16'h0020; // Open retry pulse
    localparam logic [15:0] OPEN_RETRY_OFF_CYCLES  = 16'h0100; // Open retry off

    // ------------------------------------------------------------------
    // Per-channel state, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_NORMAL   = 5'h01,  // Regulating, PWM in control
        ST_SG_ON    = 5'h02,  // Ground-short retry pulse
        ST_SG_OFF   = 5'h04,  // Ground-short retry pause
        ST_OPEN_ON  = 5'h08,  // Open / battery-short retry pulse
        ST_OPEN_OFF = 5'h10   // Open / battery-short retry pause
    } chan_state_type;

endpackage
